// ===== hdl/mem_space_defs.svh
`ifndef MEM_SPACE_DEFS_SVH
`define MEM_SPACE_DEFS_SVH

// Data memory map
`define IRAM_BYTES 256
`define LOWER_TOP 8'h7f
`define BANK_TOP 8'h1f
`define BITRAM_BASE 8'h20
`define BITRAM_TOP 8'h2f
`define STATUS_BANK_LSB 3
`define STATUS_BANK_MSB 4
// Program memory map
`define FLASH_TOP 16'h807f
`define FACTORY_BASE 16'h7e00
`define FACTORY_TOP 16'h7fff
`define STORE_WEN_BIT 0
// External RAM
`define XRAM_BYTES 2048
`define XRAM_AW 11

`endif

// ===== hdl/mem_space_pkg.sv
package mem_space_pkg;
    // Kind of instruction issuing the access
    typedef enum logic [2:0] {
        acc_direct,
        acc_indirect,
        acc_bit,
        acc_code,
        acc_external
    } access_kind_t;

    // Decoded target of an access
    typedef enum logic [2:0] {
        tgt_none,
        tgt_iram,
        tgt_sfr,
        tgt_flash,
        tgt_xram
    } target_t;

    // Request from the core's execute logic
    typedef struct packed {
        logic valid;
        logic write;
        access_kind_t kind;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wbit;
        logic use_pointer;
        logic pointer_sel;
    } mem_req_t;

    // Request forwarded to the special function register file
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // Write request into program flash
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] wdata;
    } flash_wr_t;
endpackage

// ===== hdl/core_memory_space_decoder.sv
// Operation
// - 256 bytes internal RAM at 0x00-0xFF
// - lower 128 bytes reachable direct or indirect
// - 0x00-0x1F form four eight-register banks
// - program status word bits 3,4 pick bank
// - indirect pointer from register zero or one
// - 0x20-0x2F accessible as bytes or bits
// - bit address maps to byte 0x20+n/8
// - bit or byte access by instruction type
// - upper 128 bytes only by indirect addressing
// - direct above 0x7F goes to SPECIAL_FUNCTION_REGISTER space
// - indirect above 0x7F goes to upper RAM
// - instruction type selects program or data
// - flash 32896 bytes from 0x0000 to 0x807F
// - program writes only with write-enable bit set
// - 2048 byte external RAM via external moves
`timescale 1ns/100ps
`include "mem_space_defs.svh"

module core_memory_space_decoder
    import mem_space_pkg::*;
#(
    parameter int XRAM_PRESENT = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire mem_req_t req,
    input wire logic [7:0] program_status_word,
    input wire logic [7:0] flash_program_control,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] flash_rdata,
    output logic [7:0] rdata,
    output logic rbit,
    output logic rvalid,
    output target_t target,
    output logic [7:0] pointer_value,
    output sfr_req_t sfr_req,
    output flash_wr_t flash_wr,
    output logic [15:0] flash_raddr,
    output logic access_error
);

    // ----------------------------------------------------------------
    // Limits a user must know
    // ----------------------------------------------------------------
    // The factory range inside flash is not guarded; software keeps out
    // Bit addresses above 0x7F reach the register file as byte requests
    // External reads still reach external RAM while stores are open
    // A store outside the flash block is refused and flagged
    // Arrays hold no reset value; contents are unknown until written

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] iram [`IRAM_BYTES];
    logic [7:0] xram [`XRAM_BYTES];

    // ----------------------------------------------------------------
    // Combinational decode
    // ----------------------------------------------------------------
    logic [1:0] bank;
    logic [7:0] ptr_addr;
    logic [7:0] ptr_data;
    logic [7:0] eff_addr;
    logic [7:0] bit_byte;
    logic [2:0] bit_pos;
    target_t next_target;
    logic iram_wr;
    logic xram_wr;
    logic bad;

    // Active bank comes straight from the status word each access
    assign bank = program_status_word[`STATUS_BANK_MSB:`STATUS_BANK_LSB];
    // Working register zero or one of the active bank
    assign ptr_addr = {3'h0, bank, 2'h0, req.pointer_sel};
    assign ptr_data = iram[ptr_addr];
    // Bit n lives in byte 0x20 + n/8, position n mod 8
    assign bit_byte = `BITRAM_BASE + {4'h0, req.addr[6:3]};
    assign bit_pos = req.addr[2:0];

    // ----------------------------------------------------------------
    // Range tests on the full address
    // ----------------------------------------------------------------
    logic in_flash;
    logic in_xram;
    logic store_open;

    // One compare each; in_flash is shared by the code and external branches, in_xram serves external only
    assign in_flash = req.addr <= `FLASH_TOP;
    assign in_xram = (XRAM_PRESENT != 0) && (req.addr < 16'(`XRAM_BYTES));
    // Stores need a write and the enable bit; reads never divert
    assign store_open = req.write && flash_program_control[`STORE_WEN_BIT];

    // Route by instruction kind, then by address and mode
    always_comb begin
        next_target = tgt_none;
        eff_addr = req.addr[7:0];
        bad = 1'b0;
        if (req.use_pointer) begin
            eff_addr = ptr_data;
        end
        unique case (req.kind)
            acc_direct: begin
                // Same byte as indirect below 0x80, SFRs above
                if (eff_addr > `LOWER_TOP) begin
                    next_target = tgt_sfr;
                end else begin
                    next_target = tgt_iram;
                end
            end
            acc_indirect: begin
                next_target = tgt_iram;
            end
            acc_bit: begin
                // Bit addresses above 0x7F name register bits; passed on, not flagged
                if (req.addr[7]) begin
                    next_target = tgt_sfr;
                end else begin
                    next_target = tgt_iram;
                end
                eff_addr = bit_byte;
            end
            acc_code: begin
                // Reads beyond the flash block return nothing
                if (req.write || !in_flash) begin
                    bad = 1'b1;
                end else begin
                    next_target = tgt_flash;
                end
            end
            acc_external: begin
                // Program store write enable diverts external writes to flash
                if (store_open) begin
                    next_target = tgt_flash;
                    bad = !in_flash;
                end else if (in_xram) begin
                    next_target = tgt_xram;
                end else begin
                    bad = 1'b1;
                end
            end
            default: begin
                bad = 1'b1;
            end
        endcase
        if (!req.valid) begin
            next_target = tgt_none;
            bad = 1'b0;
        end
    end

    assign iram_wr = req.valid && req.write && next_target == tgt_iram;
    assign xram_wr = req.valid && req.write && next_target == tgt_xram;
    assign flash_raddr = req.addr;

    // Forwarded requests are combinational handshakes
    always_comb begin
        sfr_req.valid = req.valid && next_target == tgt_sfr;
        sfr_req.write = req.write;
        sfr_req.addr = eff_addr;
        sfr_req.wdata = req.wdata;
        flash_wr.valid = req.valid && req.write && next_target == tgt_flash
                         && !bad;
        flash_wr.addr = req.addr;
        flash_wr.wdata = req.wdata;
    end

    // ----------------------------------------------------------------
    // Memory writes; arrays carry no reset, like real RAM
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (iram_wr) begin
            if (req.kind == acc_bit) begin
                iram[eff_addr][bit_pos] <= req.wbit;
            end else begin
                iram[eff_addr] <= req.wdata;
            end
        end
        if (xram_wr) begin
            xram[req.addr[`XRAM_AW-1:0]] <= req.wdata;
        end
    end

    // ----------------------------------------------------------------
    // Read data, one cycle after the request
    // ----------------------------------------------------------------
    logic [7:0] next_rdata;
    logic next_rbit;
    logic next_rvalid;
    logic [7:0] next_pointer_value;

    always_comb begin
        next_rdata = 8'h00;
        unique case (next_target)
            tgt_iram: next_rdata = iram[eff_addr];
            tgt_sfr: next_rdata = sfr_rdata;
            tgt_flash: next_rdata = flash_rdata;
            tgt_xram: next_rdata = xram[req.addr[`XRAM_AW-1:0]];
            tgt_none: next_rdata = 8'h00;
        endcase
        next_rbit = (req.kind == acc_bit) ? next_rdata[bit_pos] : 1'b0;
        next_rvalid = req.valid && !req.write && !bad;
        next_pointer_value = ptr_data;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
            rbit <= 1'b0;
            rvalid <= 1'b0;
            target <= tgt_none;
            access_error <= 1'b0;
            pointer_value <= 8'h00;
        end else begin
            rdata <= next_rdata;
            rbit <= next_rbit;
            rvalid <= next_rvalid;
            target <= next_target;
            access_error <= bad;
            pointer_value <= next_pointer_value;
        end
    end

endmodule // core_memory_space_decoder

// ===== dv/mem_space_chk.sv
`timescale 1ns/100ps
// ------------------------------
// Port checker for the decoder
// ------------------------------
module mem_space_chk
    import mem_space_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire mem_req_t req,
    input wire logic [7:0] flash_program_control,
    input wire logic [7:0] flash_rdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire target_t target,
    input wire sfr_req_t sfr_req,
    input wire flash_wr_t flash_wr,
    input wire logic access_error
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Request classes, so each property stays on a short line
    wire dr = req.valid && req.kind == acc_direct;
    wire cd = req.valid && req.kind == acc_code;
    wire ex = req.valid && req.kind == acc_external;
    wire id = req.valid && req.kind == acc_indirect && !req.use_pointer;

    low_direct_a: assert property (dr && !req.addr[7] |->
        !sfr_req.valid ##1 target == tgt_iram) else $error("low direct not in ram");
    dir_sfr_a: assert property (dr && req.addr[7] |->
        sfr_req.valid && sfr_req.addr == req.addr[7:0] && sfr_req.write == req.write
        && sfr_req.wdata == req.wdata ##1 target == tgt_sfr)
        else $error("direct upper not in sfr space");
    ind_upper_a: assert property (id && req.addr[7] |->
        !sfr_req.valid ##1 target == tgt_iram) else $error("indirect upper left ram");
    flash_gate_a: assert property (flash_wr.valid |-> flash_program_control[0])
        else $error("flash write without enable");
    code_wr_block_a: assert property (cd && req.write |->
        !flash_wr.valid ##1 access_error && !rvalid) else $error("code write taken");
    flash_read_a: assert property (cd && !req.write && req.addr <= 16'h807f |=>
        rvalid && target == tgt_flash && rdata == $past(flash_rdata)) else $error("flash read");
    flash_top_a: assert property (cd && req.addr > 16'h807f |=> access_error && !rvalid)
        else $error("read past flash top");
    xram_range_a: assert property (ex && !req.write && req.addr > 16'h07ff |=> access_error)
        else $error("external read out of range");
    store_write_a: assert property (ex && req.write && flash_program_control[0] &&
        req.addr <= 16'h807f |-> flash_wr.valid && flash_wr.addr == req.addr
        && flash_wr.wdata == req.wdata)
        else $error("program store write lost");
endmodule // mem_space_chk

// ===== dv/far_store.sv
`timescale 1ns/100ps
// ------------------------------
// Storage beside the decoder
// ------------------------------
module far_store
    import mem_space_pkg::*;
(
    input wire sfr_req_t sfr_req,
    input wire logic [15:0] flash_raddr,
    output logic [7:0] sfr_rdata,
    output logic [7:0] flash_rdata
);
    // Contents follow the address, so a read from the wrong place shows
    assign sfr_rdata = ~sfr_req.addr;
    assign flash_rdata = flash_raddr[7:0] ^ flash_raddr[15:8] ^ 8'h3c;
endmodule // far_store

// ===== dv/tb_top.sv
`timescale 1ns/100ps
// ------------------------------
// Decoder testbench
// ------------------------------
module tb_top import mem_space_pkg::*;;
    logic clk = 0;
    logic rst = 1;
    mem_req_t req = '0;
    logic [7:0] program_status_word = '0;
    logic [7:0] flash_program_control = '0;
    logic [7:0] sfr_rdata, flash_rdata, rdata, pointer_value;
    logic rbit, rvalid, access_error, sv, fv;
    target_t target;
    sfr_req_t sfr_req;
    flash_wr_t flash_wr;
    logic [15:0] flash_raddr;
    int failures = 0, total_checks = 0, cycles = 0;

    core_memory_space_decoder i_dut (
        .clk(clk),
        .rst(rst),
        .req(req),
        .program_status_word(program_status_word),
        .flash_program_control(flash_program_control),
        .sfr_rdata(sfr_rdata),
        .flash_rdata(flash_rdata),
        .rdata(rdata),
        .rbit(rbit),
        .rvalid(rvalid),
        .target(target),
        .pointer_value(pointer_value),
        .sfr_req(sfr_req),
        .flash_wr(flash_wr),
        .flash_raddr(flash_raddr),
        .access_error(access_error)
    );
    far_store i_far (
        .sfr_req(sfr_req),
        .flash_raddr(flash_raddr),
        .sfr_rdata(sfr_rdata),
        .flash_rdata(flash_rdata)
    );

    always #25 clk = ~clk;
    // Ceiling far above the roughly 116 cycles the tests take
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            complete_run();
        end
    end

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    // One request held for one taking edge; comb outputs sampled mid-cycle
    task automatic acc(access_kind_t k, logic w, logic [15:0] a, logic [7:0] d = 8'h00,
        logic b = 1'h0, logic p = 1'h0, logic s = 1'h0);
        @(posedge clk);
        req <= '{1'h1, w, k, a, d, b, p, s};
        @(negedge clk);
        sv = sfr_req.valid;
        fv = flash_wr.valid;
        @(posedge clk);
        req.valid <= 1'h0;
        #1;
    endtask

    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            acc(acc_direct, 1'h1, 16'(b * 8), 8'(8'h40 + b));
            acc(acc_direct, 1'h1, 16'(b * 8 + 1), 8'(8'h50 + b));
            acc(acc_direct, 1'h1, 16'(8'h40 + b), 8'(8'ha0 + b));
        end
        for (int b = 0; b < 4; b++) begin
            @(posedge clk) program_status_word <= 8'(b << 3);
            acc(acc_indirect, 1'h0, 16'h0000, 8'h00, 1'h0, 1'h1, 1'h0);
            chk("bank data", 16'(8'ha0 + b), rdata);
            chk("pointer zero", 16'(8'h40 + b), pointer_value);
            acc(acc_indirect, 1'h0, 16'h0000, 8'h00, 1'h0, 1'h1, 1'h1);
            chk("pointer one", 16'(8'h50 + b), pointer_value);
        end
        $display("t_banks done");
    endtask

    task automatic t_upper();
        acc(acc_indirect, 1'h1, 16'h0090, 8'h11);
        acc(acc_direct, 1'h1, 16'h0090, 8'h77);
        chk("sfr strobe", 1'h1, sv);
        chk("write valid", 1'h0, rvalid);
        acc(acc_indirect, 1'h0, 16'h0090);
        chk("upper ram", 8'h11, rdata);
        chk("upper valid", 1'h1, rvalid);
        acc(acc_direct, 1'h0, 16'h0090);
        chk("sfr data", 8'h6f, rdata);
        chk("sfr target", tgt_sfr, target);
        $display("t_upper done");
    endtask

    task automatic t_bits();
        acc(acc_direct, 1'h1, 16'h0022, 8'h00);
        acc(acc_bit, 1'h1, 16'h0013, 8'h00, 1'h1);
        acc(acc_direct, 1'h0, 16'h0022);
        chk("bit byte", 8'h08, rdata);
        acc(acc_direct, 1'h1, 16'h002f, 8'h80);
        acc(acc_bit, 1'h0, 16'h007f);
        chk("top bit", 1'h1, rbit);
        acc(acc_bit, 1'h0, 16'h007e);
        chk("next bit", 1'h0, rbit);
        acc(acc_bit, 1'h0, 16'h0086);
        chk("bit to sfr", 1'h1, sv);
        chk("bit sfr target", tgt_sfr, target);
        $display("t_bits done");
    endtask

    task automatic t_code();
        acc(acc_code, 1'h0, 16'h807f);
        chk("flash top", 8'hc3, rdata);
        acc(acc_code, 1'h0, 16'h8080);
        chk("past top", 1'h1, access_error);
        acc(acc_code, 1'h1, 16'h0100, 8'h55);
        chk("code write", 2'h2, {access_error, fv});
        acc(acc_external, 1'h1, 16'h0100, 8'h55);
        chk("store closed", 1'h0, fv);
        @(posedge clk) flash_program_control <= 8'h01;
        acc(acc_external, 1'h1, 16'h0100, 8'h66);
        chk("store open", 1'h1, fv);
        acc(acc_external, 1'h1, 16'h9000, 8'h77);
        chk("store past top", 2'h2, {access_error, fv});
        @(posedge clk) flash_program_control <= 8'h00;
        $display("t_code done");
    endtask

    task automatic t_xram();
        acc(acc_external, 1'h1, 16'h07ff, 8'h3a);
        acc(acc_direct, 1'h1, 16'h0030, 8'h99);
        acc(acc_external, 1'h1, 16'h0030, 8'h5b);
        acc(acc_external, 1'h0, 16'h07ff);
        chk("xram top", 8'h3a, rdata);
        chk("xram error", 1'h0, access_error);
        acc(acc_external, 1'h0, 16'h0030);
        chk("xram space", 8'h5b, rdata);
        acc(acc_code, 1'h0, 16'h0030);
        chk("code space", 8'h0c, rdata);
        acc(acc_direct, 1'h0, 16'h0030);
        chk("data space", 8'h99, rdata);
        acc(acc_external, 1'h0, 16'h0800);
        chk("xram past", 1'h1, access_error);
        $display("t_xram done");
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        t_banks();
        t_upper();
        t_bits();
        t_code();
        t_xram();
        complete_run();
    end
endmodule // tb_top

bind core_memory_space_decoder mem_space_chk i_chk (
    .clk(clk),
    .rst(rst),
    .req(req),
    .flash_program_control(flash_program_control),
    .flash_rdata(flash_rdata),
    .rdata(rdata),
    .rvalid(rvalid),
    .target(target),
    .sfr_req(sfr_req),
    .flash_wr(flash_wr),
    .access_error(access_error)
);
